/* File: verilog/cin_defines.svh */
`ifndef CIN_DEFINES_SVH
`define CIN_DEFINES_SVH

// Clock and timing
`define CIN_CLK_PERIOD_NS 4
`define CIN_NS_PER_US 1000
`define CIN_BT_RESET_MIN_US 50
`define CIN_BT_RESET_MIN_CYC ((`CIN_BT_RESET_MIN_US * `CIN_NS_PER_US) / `CIN_CLK_PERIOD_NS)
`define CIN_CAL_REPEAT_BITS 8192
`define CIN_BIT_CNT_W 14

// Calibration spans: 32 bits in a calibration span, two bits between falls of 1010
`define CIN_CAL_SPAN_SHIFT 5
`define CIN_ROUGH_EDGE_SHIFT 1

// Widths
`define CIN_PORT_PINS 17
`define CIN_ID_W 11
`define CIN_STRAP_W 4
`define CIN_ADDR_W 8
`define CIN_DATA_W 32
`define CIN_SEL_W 4
`define CIN_BM_W 2

// Node identifier bits taken from the strap pins
`define CIN_ID_BIT_EIGHT 8
`define CIN_ID_BIT_FIVE 5
`define CIN_ID_BIT_FOUR 4
`define CIN_ID_BIT_THREE 3
`define CIN_STRAP_FOR_EIGHT 3
`define CIN_STRAP_FOR_FIVE 2
`define CIN_STRAP_FOR_FOUR 1
`define CIN_STRAP_FOR_THREE 0

// Register byte offsets
`define CIN_REG_CTRL 8'h00
`define CIN_REG_STATUS 8'h04
`define CIN_REG_PORT_OUT 8'h08
`define CIN_REG_PORT_OE 8'h0c
`define CIN_REG_DATA_IN 8'h10
`define CIN_REG_BIT_TIME 8'h14
`define CIN_REG_NODE_ID 8'h18

// Status register fields
`define CIN_ST_CALIBRATED 0
`define CIN_ST_ROUGH 1
`define CIN_ST_RESET_IND 2
`define CIN_ST_ERR_WARN 3
`define CIN_ST_BM_LOW 4
`define CIN_ST_BM_HIGH 5
`define CIN_ST_SIGNON_PEND 6

// Bus modes
`define CIN_BM_DIFF 2'h0
`define CIN_BM_ONE_RX1 2'h1
`define CIN_BM_ONE_RX0 2'h2
`define CIN_BM_SLEEP 2'h3

// Reset values
`define CIN_RESET_IND_INIT 1'h1
`define CIN_ERR_WARN_INIT 1'h1
`define CIN_BM_INIT 2'h0

`endif

/* File: verilog/cin_pkg.sv */
`include "cin_defines.svh"

package cin_pkg;

	typedef enum logic [1:0] {
		CIN_UNCAL,
		CIN_ROUGH,
		CIN_ROUGH_PLUS,
		CIN_FULL
	} cin_cal_state_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [`CIN_ADDR_W-1:0] adr;
		logic [`CIN_SEL_W-1:0] sel;
		logic [`CIN_DATA_W-1:0] dat;
	} cin_wb_req_t;

	typedef struct packed {
		logic msg_done;
		logic msg_ok;
		logic ack_missing_only;
		logic is_cal;
		logic cal_span_start;
		logic cal_span_end;
	} cin_rx_event_t;

	typedef struct packed {
		logic reset_indicator_flag;
		logic error_warning_flag;
		logic bus_mode_bit_high;
		logic bus_mode_bit_low;
	} cin_frame_status_t;

endpackage : cin_pkg

/* File: verilog/cin_init_cal.sv */
// Functional notes
// - Identifier bits 8,5,4,3 come from strap pins 3,2,1,0; rest fixed.
// - All output drivers, strap pins included, stay disabled during reset.
// - Strap levels are latched when reset ends; pins then serve as ports.
// - Port drivers 16..0 and both CAN transmit outputs are off while reset high.
// - Reset clears every I/O register to zero.
// - Reset sets the bit-time measure above 50 microseconds.
// - Reset and test both high select external clock on port pin 0.
// - After reset: reset indicator 1, error warning 1, bus mode bits 0.
// - Calibration needs at least three messages after reset or bus mode change.
// - First message gives rough bit time from two consecutive falling receive edges.
// - Rough calibrated node receives and acts, but never acknowledges.
// - One more valid message plus a calibration message make it calibrated; sign-on follows.
// - Acknowledge and transmit only while fully calibrated.
// - A message failing only for missing acknowledge still counts as valid.
// - Sign-on frame sent once on entering calibration, carrying the data input.
// - Reset indicator reads 1 in the first sign-on frame after reset, 0 in all others.
// - Error warning reads 1 in the first sign-on frame after reset though error counters are zero.
// - No frame is transmitted before calibration by calibration messages.
// - Calibration message spans exactly 32 bits between its two marked falling edges.
`timescale 1ns/1ns

module cin_init_cal
	import cin_pkg::*;
#(
	parameter int unsigned BT_W = 24,
	parameter logic [BT_W-1:0] RESET_BIT_CYCLES = BT_W'(`CIN_BT_RESET_MIN_CYC + 1),
	parameter logic [`CIN_BIT_CNT_W-1:0] CAL_REPEAT_BITS = `CIN_BIT_CNT_W'(`CIN_CAL_REPEAT_BITS),
	parameter logic [`CIN_ID_W-1:0] FIXED_ID = 11'h000
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic test_pin,
	input wire logic [`CIN_PORT_PINS-1:0] port_in,
	input wire logic rx_level,
	input wire cin_rx_event_t rx_evt,
	input wire logic tx_dominant_req,
	input wire logic sign_on_done,
	input wire cin_wb_req_t wb_req,
	output logic wb_ack,
	output logic [`CIN_DATA_W-1:0] wb_dat_o,
	output logic [`CIN_PORT_PINS-1:0] port_out,
	output logic [`CIN_PORT_PINS-1:0] port_oe,
	output logic can_tx_pulldown_output,
	output logic can_tx_pulldown_oe,
	output logic can_tx_pullup_output,
	output logic can_tx_pullup_oe,
	output logic rx_enable,
	output logic calibrated,
	output logic [BT_W-1:0] bit_time,
	output logic [`CIN_ID_W-1:0] node_id,
	output logic sign_on_req,
	output logic [`CIN_PORT_PINS-1:0] sign_on_data,
	output cin_frame_status_t frame_status,
	output logic ext_clk_select
);

	function automatic logic [BT_W-1:0] sat_inc(input logic [BT_W-1:0] v);
		sat_inc = (&v) ? v : v + BT_W'(1);
	endfunction : sat_inc
	function automatic logic [`CIN_DATA_W-1:0] merge_bytes(
		input logic [`CIN_DATA_W-1:0] old_v,
		input logic [`CIN_DATA_W-1:0] new_v,
		input logic [`CIN_SEL_W-1:0] sel
	);
		logic [`CIN_DATA_W-1:0] r;
		r = old_v;
		for (int i = 0; i < `CIN_SEL_W; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		merge_bytes = r;
	endfunction : merge_bytes
	cin_cal_state_t state;
	cin_cal_state_t next_state;
	logic [`CIN_BM_W-1:0] bus_mode;
	logic reset_indicator_flag;
	logic error_warning_flag;
	logic strap_pending;
	logic rx_prev;
	logic edge_seen;
	logic [BT_W-1:0] gap_cnt;
	logic [BT_W-1:0] best_gap;
	logic best_valid;
	logic span_run;
	logic span_ok;
	logic [BT_W-1:0] span_cnt;
	logic [BT_W-1:0] span_len;
	logic [BT_W-1:0] tick_cnt;
	logic [`CIN_BIT_CNT_W-1:0] bits_since_cal;
	logic [`CIN_DATA_W-1:0] rd_word;
	logic [`CIN_DATA_W-1:0] status_word;
	logic [`CIN_DATA_W-1:0] wr_merged;
	logic wb_hit;
	logic wb_wr;
	logic mode_change;
	logic rx_fall;
	logic msg_valid;
	logic cal_valid;
	logic watchdog_expired;
	logic enter_full;
	logic [`CIN_BM_W-1:0] new_mode;
	assign wb_hit = wb_req.cyc && wb_req.stb && !wb_ack;
	assign wb_wr = wb_hit && wb_req.we;
	assign rx_fall = rx_prev && !rx_level;
	assign msg_valid = rx_evt.msg_done && (rx_evt.msg_ok || rx_evt.ack_missing_only);
	assign cal_valid = msg_valid && rx_evt.is_cal && span_ok;
	assign watchdog_expired = (state == CIN_FULL) && (bits_since_cal >= CAL_REPEAT_BITS);
	assign enter_full = (next_state == CIN_FULL) && (state != CIN_FULL);
	always_comb begin
		wr_merged = merge_bytes(`CIN_DATA_W'(bus_mode), wb_req.dat, wb_req.sel);
		new_mode = wr_merged[`CIN_BM_W-1:0];
		mode_change = wb_wr && (wb_req.adr == `CIN_REG_CTRL) && (new_mode != bus_mode);
	end
	// Calibration sequence
	always_comb begin
		next_state = state;
		unique case (state)
			CIN_UNCAL: begin
				if (rx_evt.msg_done && best_valid) begin
					next_state = CIN_ROUGH;
				end
			end
			CIN_ROUGH: begin
				if (msg_valid) begin
					next_state = CIN_ROUGH_PLUS;
				end
			end
			CIN_ROUGH_PLUS: begin
				if (cal_valid) begin
					next_state = CIN_FULL;
				end
			end
			CIN_FULL: begin
				// Host missed its repeat window; bit time is no longer trusted
				if (watchdog_expired) begin
					next_state = CIN_ROUGH;
				end
			end
		endcase
		if (mode_change) begin
			next_state = CIN_UNCAL;
		end
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state <= CIN_UNCAL;
			rx_enable <= 1'h0;
			calibrated <= 1'h0;
		end else begin
			state <= next_state;
			rx_enable <= next_state != CIN_UNCAL;
			calibrated <= next_state == CIN_FULL;
		end
	end
	// Strap capture at the first edge after reset release
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			strap_pending <= 1'h1;
			node_id <= '0;
		end else if (strap_pending) begin
			strap_pending <= 1'h0;
			node_id <= FIXED_ID;
			node_id[`CIN_ID_BIT_EIGHT] <= port_in[`CIN_STRAP_FOR_EIGHT];
			node_id[`CIN_ID_BIT_FIVE] <= port_in[`CIN_STRAP_FOR_FIVE];
			node_id[`CIN_ID_BIT_FOUR] <= port_in[`CIN_STRAP_FOR_FOUR];
			node_id[`CIN_ID_BIT_THREE] <= port_in[`CIN_STRAP_FOR_THREE];
		end
	end
	// Sampled without reset on purpose: the mode is decided while reset is high
	always_ff @(posedge clk_sys) begin
		ext_clk_select <= rst && test_pin;
	end
	// Rough measure: shortest gap between falls, which for 1010 is two bits
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rx_prev <= 1'h1;
			edge_seen <= 1'h0;
			gap_cnt <= '0;
			best_gap <= '1;
			best_valid <= 1'h0;
		end else begin
			rx_prev <= rx_level;
			if (state != CIN_UNCAL || mode_change) begin
				edge_seen <= 1'h0;
				best_gap <= '1;
				best_valid <= 1'h0;
				gap_cnt <= '0;
			end else if (rx_fall) begin
				edge_seen <= 1'h1;
				gap_cnt <= BT_W'(1);
				if (edge_seen && gap_cnt < best_gap) begin
					best_gap <= gap_cnt;
					best_valid <= 1'h1;
				end
			end else begin
				gap_cnt <= sat_inc(gap_cnt);
			end
		end
	end
	// Fine measure over the 32-bit span of a calibration message
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			span_run <= 1'h0;
			span_ok <= 1'h0;
			span_cnt <= '0;
			span_len <= '0;
		end else begin
			if (rx_evt.cal_span_start) begin
				span_run <= 1'h1;
				span_ok <= 1'h0;
				span_cnt <= BT_W'(1);
			end else if (span_run && rx_evt.cal_span_end) begin
				span_run <= 1'h0;
				span_ok <= 1'h1;
				span_len <= span_cnt;
			end else if (span_run) begin
				span_cnt <= sat_inc(span_cnt);
			end
			if (rx_evt.msg_done) begin
				span_run <= 1'h0;
				span_ok <= 1'h0;
			end
		end
	end
	// Bit time register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			bit_time <= RESET_BIT_CYCLES;
		end else if (mode_change) begin
			bit_time <= RESET_BIT_CYCLES;
		end else if (state == CIN_UNCAL && rx_evt.msg_done && best_valid) begin
			bit_time <= best_gap >> `CIN_ROUGH_EDGE_SHIFT;
		end else if (state != CIN_UNCAL && cal_valid) begin
			bit_time <= span_len >> `CIN_CAL_SPAN_SHIFT;
		end
	end
	// Bit-time ticks since the last calibration message
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tick_cnt <= '0;
			bits_since_cal <= '0;
		end else if (state != CIN_FULL || cal_valid) begin
			tick_cnt <= '0;
			bits_since_cal <= '0;
		end else if (tick_cnt + BT_W'(1) >= bit_time) begin
			tick_cnt <= '0;
			if (!watchdog_expired) begin
				bits_since_cal <= bits_since_cal + `CIN_BIT_CNT_W'(1);
			end
		end else begin
			tick_cnt <= tick_cnt + BT_W'(1);
		end
	end
	// Sign-on request held until the frame engine reports it sent or calibration is lost
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sign_on_req <= 1'h0;
			sign_on_data <= '0;
		end else if (enter_full) begin
			sign_on_req <= 1'h1;
			sign_on_data <= port_in;
		end else if (sign_on_done || next_state != CIN_FULL) begin
			sign_on_req <= 1'h0;
		end
	end
	// Status flags; set only by reset, cleared after sign-on unless entry comes in the same cycle
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reset_indicator_flag <= `CIN_RESET_IND_INIT;
			error_warning_flag <= `CIN_ERR_WARN_INIT;
		end else if (sign_on_req && sign_on_done && !enter_full) begin
			reset_indicator_flag <= 1'h0;
			error_warning_flag <= 1'h0;
		end
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			frame_status <= '0;
		end else begin
			frame_status.reset_indicator_flag <= reset_indicator_flag;
			frame_status.error_warning_flag <= error_warning_flag;
			frame_status.bus_mode_bit_high <= bus_mode[1];
			frame_status.bus_mode_bit_low <= bus_mode[0];
		end
	end
	// Transmit drivers: open drain, only level enables ever change
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			can_tx_pulldown_output <= 1'h0;
			can_tx_pullup_output <= 1'h1;
			can_tx_pulldown_oe <= 1'h0;
			can_tx_pullup_oe <= 1'h0;
		end else begin
			can_tx_pulldown_output <= 1'h0;
			can_tx_pullup_output <= 1'h1;
			can_tx_pulldown_oe <= calibrated && tx_dominant_req &&
				bus_mode != `CIN_BM_SLEEP;
			can_tx_pullup_oe <= calibrated && tx_dominant_req &&
				(bus_mode == `CIN_BM_DIFF || bus_mode == `CIN_BM_ONE_RX1);
		end
	end
	// Control and port registers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			bus_mode <= `CIN_BM_INIT;
		end else if (mode_change) begin
			bus_mode <= new_mode;
		end
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			port_out <= '0;
			port_oe <= '0;
		end else if (wb_wr) begin
			if (wb_req.adr == `CIN_REG_PORT_OUT) begin
				port_out <= `CIN_PORT_PINS'(merge_bytes(`CIN_DATA_W'(port_out),
					wb_req.dat, wb_req.sel));
			end
			if (wb_req.adr == `CIN_REG_PORT_OE) begin
				port_oe <= `CIN_PORT_PINS'(merge_bytes(`CIN_DATA_W'(port_oe),
					wb_req.dat, wb_req.sel));
			end
		end
	end
	always_comb begin
		status_word = '0;
		status_word[`CIN_ST_CALIBRATED] = state == CIN_FULL;
		status_word[`CIN_ST_ROUGH] = state != CIN_UNCAL;
		status_word[`CIN_ST_RESET_IND] = reset_indicator_flag;
		status_word[`CIN_ST_ERR_WARN] = error_warning_flag;
		status_word[`CIN_ST_BM_LOW] = bus_mode[0];
		status_word[`CIN_ST_BM_HIGH] = bus_mode[1];
		status_word[`CIN_ST_SIGNON_PEND] = sign_on_req;
		unique case (wb_req.adr)
			`CIN_REG_CTRL: rd_word = `CIN_DATA_W'(bus_mode);
			`CIN_REG_STATUS: rd_word = status_word;
			`CIN_REG_PORT_OUT: rd_word = `CIN_DATA_W'(port_out);
			`CIN_REG_PORT_OE: rd_word = `CIN_DATA_W'(port_oe);
			`CIN_REG_DATA_IN: rd_word = `CIN_DATA_W'(port_in);
			`CIN_REG_BIT_TIME: rd_word = `CIN_DATA_W'(bit_time);
			`CIN_REG_NODE_ID: rd_word = `CIN_DATA_W'(node_id);
			default: rd_word = '0;
		endcase
	end
	// Wishbone slave: ack one edge after the request, dropped the next
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wb_ack <= 1'h0;
			wb_dat_o <= '0;
		end else begin
			wb_ack <= wb_hit;
			if (wb_hit && !wb_req.we) begin
				wb_dat_o <= rd_word;
			end
		end
	end

endmodule : cin_init_cal

/* File: verification/cin_init_cal_properties.sv */
`timescale 1ns/1ns
`include "cin_defines.svh"

module cin_init_cal_properties
	import cin_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [`CIN_PORT_PINS-1:0] port_in,
	input wire cin_wb_req_t wb_req,
	input wire logic wb_ack,
	input wire logic [`CIN_PORT_PINS-1:0] port_oe,
	input wire logic can_tx_pulldown_oe,
	input wire logic can_tx_pullup_oe,
	input wire logic tx_dominant_req,
	input wire cin_rx_event_t rx_evt,
	input wire logic rx_enable,
	input wire logic calibrated,
	input wire logic [`CIN_ID_W-1:0] node_id,
	input wire logic sign_on_req,
	input wire logic sign_on_done,
	input wire cin_frame_status_t frame_status
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence s_take;
		wb_req.cyc && wb_req.stb && !wb_ack;
	endsequence
	sequence s_rel;
		$fell(rst);
	endsequence
	// Drivers must be off during reset itself, so no disable here
	property p_oe_rst;
		disable iff (1'b0) rst |-> port_oe == 0 && !can_tx_pulldown_oe && !can_tx_pullup_oe;
	endproperty
	property p_ack;
		s_take |=> wb_ack;
	endproperty
	property p_ack_one;
		wb_ack |=> !wb_ack;
	endproperty
	property p_id;
		s_rel |=> node_id == {2'h0, $past(port_in[3]), 2'h0, $past(port_in[2:0]), 3'h0};
	endproperty
	property p_st;
		s_rel |=> frame_status == 4'hc;
	endproperty
	property p_tx;
		(can_tx_pulldown_oe || can_tx_pullup_oe) |->
			$past(tx_dominant_req && calibrated) || $past(tx_dominant_req && calibrated, 2);
	endproperty
	property p_cal_seq;
		$rose(calibrated) |-> $past(rx_enable) && sign_on_req;
	endproperty
	property p_rough;
		$rose(rx_enable) |-> $past(rx_evt.msg_done);
	endproperty
	property p_flags;
		sign_on_done && sign_on_req |-> ##2 !frame_status.reset_indicator_flag
			&& !frame_status.error_warning_flag;
	endproperty
	a_oe_rst: assert property (p_oe_rst) else $error("driver on in reset");
	a_ack: assert property (p_ack) else $error("missing ack");
	a_ack_one: assert property (p_ack_one) else $error("ack too long");
	a_id: assert property (p_id) else $error("node id wrong");
	a_st: assert property (p_st) else $error("status after reset wrong");
	a_tx: assert property (p_tx) else $error("tx while not calibrated");
	a_cal_seq: assert property (p_cal_seq) else $error("bad calibration entry");
	a_rough: assert property (p_rough) else $error("rough without message");
	a_flags: assert property (p_flags) else $error("flags not cleared");
endmodule : cin_init_cal_properties

bind cin_init_cal cin_init_cal_properties u_props (.clk_sys, .rst, .port_in, .wb_req,
	.wb_ack, .port_oe, .can_tx_pulldown_oe, .can_tx_pullup_oe, .tx_dominant_req, .rx_evt,
	.rx_enable, .calibrated, .node_id, .sign_on_req, .sign_on_done, .frame_status);

/* File: verification/cin_host_model.sv */
`timescale 1ns/1ns

module cin_host_model
	import cin_pkg::*;
#(
	parameter int B = 8
) (
	input wire logic clk_sys,
	input wire logic sign_on_req,
	output cin_rx_event_t rx_evt,
	output logic rx_level,
	output logic tx_dominant_req,
	output logic sign_on_done
);
	initial begin
		rx_evt = '0;
		rx_level = 1'b1;
		tx_dominant_req = 1'b0;
		sign_on_done = 1'b0;
	end
	task automatic pulse(input cin_rx_event_t e);
		rx_evt <= e;
		@(posedge clk_sys);
		rx_evt <= '0;
	endtask : pulse
	task automatic msg(input logic ok, input logic am, input logic cal);
		for (int i = 0; i < 6; i++) begin
			rx_level <= ~i[0];
			repeat (B) @(posedge clk_sys);
		end
		rx_level <= 1'b1;
		if (cal) begin
			pulse(6'h02);
			repeat (32 * B - 1) @(posedge clk_sys);
			pulse(6'h01);
			@(posedge clk_sys);
		end
		// Engine asks for the ack slot; node must refuse until calibrated
		tx_dominant_req <= 1'b1;
		pulse({1'b1, ok, am, cal, 2'h0});
		tx_dominant_req <= 1'b0;
	endtask : msg
	always begin
		@(posedge clk_sys);
		if (sign_on_req === 1'b1) begin
			tx_dominant_req <= 1'b1;
			repeat (B) @(posedge clk_sys);
			tx_dominant_req <= 1'b0;
			sign_on_done <= 1'b1;
			@(posedge clk_sys);
			sign_on_done <= 1'b0;
		end
	end
endmodule : cin_host_model

/* File: verification/tb_can_io_node_init_calibration.sv */
`timescale 1ns/1ns
`include "cin_defines.svh"
`define CHK(n, e, a) n_checks++; if ((a) !== (e)) begin error_cnt++; $display("MISMATCH %s exp %0h got %0h", n, e, a); end

module tb_can_io_node_init_calibration
	import cin_pkg::*;
;
	logic clk_sys, rst, test_pin, rx_level, tx_dominant_req, sign_on_done, wb_ack;
	logic can_tx_pulldown_output, can_tx_pulldown_oe, can_tx_pullup_output, can_tx_pullup_oe;
	logic rx_enable, calibrated, sign_on_req, ext_clk_select;
	logic [16:0] port_in, port_out, port_oe, sign_on_data;
	logic [31:0] wb_dat_o;
	logic [23:0] bit_time;
	logic [10:0] node_id;
	logic [1:0] saw_tx;
	cin_rx_event_t rx_evt;
	cin_wb_req_t wb_req;
	cin_frame_status_t frame_status;
	int error_cnt, n_checks, cyc;

	cin_init_cal #(.CAL_REPEAT_BITS(14'h10)) dut (.clk_sys, .rst, .test_pin, .port_in,
		.rx_level, .rx_evt, .tx_dominant_req, .sign_on_done, .wb_req, .wb_ack, .wb_dat_o,
		.port_out, .port_oe, .can_tx_pulldown_output, .can_tx_pulldown_oe,
		.can_tx_pullup_output, .can_tx_pullup_oe, .rx_enable, .calibrated, .bit_time,
		.node_id, .sign_on_req, .sign_on_data, .frame_status, .ext_clk_select);
	cin_host_model host (.clk_sys, .sign_on_req, .rx_evt, .rx_level, .tx_dominant_req,
		.sign_on_done);

	task automatic give_verdict;
		if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		wb_req <= {2'h3, we, a, 4'hf, d};
		@(posedge clk_sys);
		while (wb_ack !== 1'b1) @(posedge clk_sys);
		wb_req <= '0;
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		`CHK("read", e, wb_dat_o)
	endtask : rd

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		saw_tx <= saw_tx | {can_tx_pulldown_oe, can_tx_pullup_oe};
		if (cyc == 20000) begin
			error_cnt++;
			give_verdict();
		end
	end

	initial begin
		// Non-blocking so the asynchronous reset sees a rising edge at time zero
		rst <= 1'b1;
		test_pin <= 1'b0;
		port_in <= 17'ha;
		wb_req <= '0;
		saw_tx = 2'h0;
		repeat (2) @(posedge clk_sys);
		`CHK("oe", 17'h0, port_oe)
		`CHK("tx_lvl", 2'h1, {can_tx_pulldown_output, can_tx_pullup_output})
		`CHK("bit_time", 24'h30d5, bit_time)
		rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		`CHK("id", 11'h110, node_id)
		port_in <= 17'h1f0f5;
		rd(8'h04, 32'h0c);
		rd(8'h0c, 32'h0);
		rd(8'h40, 32'h0);
		wb(1'b1, 8'h18, 32'h7ff);
		rd(8'h18, 32'h110);
		wb(1'b1, 8'h0c, 32'h1ffff);
		wb(1'b1, 8'h08, 32'h15555);
		`CHK("port_out", 17'h15555, port_out)
		host.msg(1'b1, 1'b0, 1'b0);
		@(posedge clk_sys);
		`CHK("rough", 1'b1, rx_enable)
		`CHK("bt_rough", 24'h8, bit_time)
		host.msg(1'b0, 1'b1, 1'b1);
		@(posedge clk_sys);
		`CHK("cal2", 1'b0, calibrated)
		`CHK("no_tx", 2'h0, saw_tx)
		host.msg(1'b0, 1'b1, 1'b1);
		@(posedge clk_sys);
		`CHK("cal3", 1'b1, calibrated)
		`CHK("bt_fine", 24'h8, bit_time)
		`CHK("son", 1'b1, sign_on_req)
		`CHK("son_data", 17'h1f0f5, sign_on_data)
		`CHK("son_st", 4'hc, frame_status)
		while (sign_on_req !== 1'b0) @(posedge clk_sys);
		repeat (2) @(posedge clk_sys);
		`CHK("st", 4'h0, frame_status)
		`CHK("tx", 2'h3, saw_tx)
		// Watchdog span is 16 bits of 8 cycles, so 200 cycles is past it
		repeat (200) @(posedge clk_sys);
		`CHK("wdog", 2'h1, {calibrated, rx_enable})
		wb(1'b1, 8'h00, 32'h1);
		@(posedge clk_sys);
		`CHK("mode", 1'b0, rx_enable)
		`CHK("bt_mode", 24'h30d5, bit_time)
		rd(8'h04, 32'h10);
		// Mode 2: only the pull-down driver may switch on during sign-on
		wb(1'b1, 8'h00, 32'h2);
		host.msg(1'b1, 1'b0, 1'b0);
		host.msg(1'b0, 1'b1, 1'b1);
		host.msg(1'b0, 1'b1, 1'b1);
		repeat (3) @(posedge clk_sys);
		`CHK("tx_mode2", 2'h2, {can_tx_pulldown_oe, can_tx_pullup_oe})
		while (sign_on_req !== 1'b0) @(posedge clk_sys);
		rst <= 1'b1;
		test_pin <= 1'b1;
		port_in <= 17'h5;
		repeat (3) @(posedge clk_sys);
		`CHK("ext", 1'b1, ext_clk_select)
		`CHK("oe_rst", 19'h0, {port_oe, can_tx_pulldown_oe, can_tx_pullup_oe})
		test_pin <= 1'b0;
		@(posedge clk_sys);
		rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		`CHK("id2", 11'h028, node_id)
		rd(8'h0c, 32'h0);
		rd(8'h04, 32'h0c);
		give_verdict();
	end
endmodule : tb_can_io_node_init_calibration
